// ### logic/csp_defines.vh
// Constants for the codec status, readout and sample port logic.
// Assumes inclusion by bare name from the design files.
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

// Host bus register addresses
`define CSP_A_FLAGS      8'h80
`define CSP_A_DEC_LEVEL  8'hD4
`define CSP_A_DEC_OFFSET 8'hD5
`define CSP_A_DEC_LINEAR 8'hD6
`define CSP_A_DEC_DELTA  8'hDA
`define CSP_A_ENC_LEVEL  8'hE4
`define CSP_A_ENC_OFFSET 8'hE5
`define CSP_A_ENC_LINEAR 8'hE6
`define CSP_A_TEST_IN    8'hE8
`define CSP_A_ENC_DELTA  8'hEA

// Status bit positions
`define CSP_S_ENC_ZERO 7
`define CSP_S_DEC_ZERO 3
`define CSP_S_ENC_VAD 6
`define CSP_S_ENC_PCM 5
`define CSP_S_ENC_ADM 4
`define CSP_S_DEC_VAD 2
`define CSP_S_DEC_PCM 1
`define CSP_S_DEC_ADM 0

// Data bytes after an address byte
`define CSP_N_NONE 2'h0
`define CSP_N_ONE  2'h1
`define CSP_N_TWO  2'h2

// Coding algorithm select
`define CSP_M_DELTA  2'h0
`define CSP_M_LINEAR 2'h1
`define CSP_M_COMP   2'h2

// Sample widths in bits
`define CSP_W_ONE  5'h01
`define CSP_W_BYTE 5'h08
`define CSP_W_WORD 5'h10

// Companded word fields
`define CSP_C_SIGN 7
`define CSP_C_EXP  6:4
`define CSP_C_MANT 3:0

// Misc constants
`define CSP_LAST_BIT  3'h7
`define CSP_BYTE_END  4'h7
`define CSP_ZERO8     8'h00
`define CSP_ZERO16    16'h0000
`define CSP_NEG_FULL  16'h8000

`endif

// ### logic/csp_shreg.v
// Sixteen-bit shift register, msb out first, serial in at lsb.
// Assumes load and shift come from logic on the same clock.
`timescale 1ns/1ps
`include "csp_defines.vh"

module csp_shreg (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // Control
   input  wire        load,
   input  wire [15:0] load_val,
   input  wire        shift,
   input  wire        ser_in,
   // State
   output reg  [15:0] q_reg
);

   ////////////////////////////////////////////////////////////////////////
   // Load wins over shift in the same cycle
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q_reg <= `CSP_ZERO16;
      end else if (load) begin
         q_reg <= load_val;
      end else if (shift) begin
         q_reg <= {q_reg[14:0], ser_in};
      end
   end

endmodule // csp_shreg

// ### logic/csp_top.v
// Codec host status/readout registers and burst or bit-serial sample port.
// Assumes host bus pins and sample port pins are asynchronous to sys_clk;
// coding engine signals share sys_clk.
// How it works
// - Status read clears pending interrupt
// - Data flags clear on servicing register access
// - Voice flags track; any change interrupts
// - Status bits seven and three read zero
// - Encoder bits: PCM, delta available/needed
// - Decoder bits: PCM, delta needed/available
// - Voice levels read non-positive sixteen bits
// - Offset readout user value; encoder may read running estimate
// - Decoder linear update may interrupt
// - Decoder delta byte every eight bits
// - Encoder linear update may interrupt
// - Encoder delta byte every eight bits
// - Address byte sets following byte count
// - Host clocks bus, msb first
// - Sample width follows coding algorithm
// - Word held; strobe and one clock
// - Data on rise after strobe, msb first
// - Continuous streaming, strobe per frame
// - Transmit floats or drives between frames
// - Non-burst moves one bit per clock
// - Companded: sign, exponent, mantissa
// - Test input replaces encoder delta bits
`timescale 1ns/1ps
`include "csp_defines.vh"

module csp_top (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // Host control bus
   input  wire        hb_clk,
   input  wire        hb_sel_n,
   input  wire        hb_cmd,
   output reg         hb_reply_reg,
   output reg         hb_reply_oe_reg,
   output reg         irq_reg,
   // Sample data port
   input  wire        dp_clk,
   input  wire        frame_sync_strobe,
   input  wire        dp_rx,
   output reg         dp_tx_reg,
   output reg         dp_tx_oe_reg,
   output reg  [15:0] rx_word_reg,
   output reg         rx_word_upd_reg,
   // Configuration
   input  wire        burst_mode,
   input  wire [1:0]  codec_mode,
   input  wire        tx_float,
   input  wire        delta_out_sel,
   input  wire        ice_enable,
   input  wire        ie_enc_linear,
   input  wire        ie_enc_delta,
   input  wire        ie_dec_linear,
   input  wire        ie_dec_delta,
   // Coding engine
   input  wire        enc_vad,
   input  wire        dec_vad,
   input  wire [15:0] enc_envelope,
   input  wire [15:0] dec_envelope,
   input  wire [15:0] enc_offset_user,
   input  wire [15:0] enc_offset_est,
   input  wire [15:0] dec_offset_user,
   input  wire [15:0] enc_linear,
   input  wire        enc_linear_upd,
   input  wire [15:0] dec_linear,
   input  wire        dec_linear_upd,
   input  wire        enc_sign,
   input  wire [2:0]  enc_exp,
   input  wire [3:0]  enc_mant,
   input  wire        enc_delta_bit,
   input  wire        enc_delta_upd,
   input  wire        dec_delta_bit,
   input  wire        dec_delta_upd
);

   localparam [1:0] ST_ADDR  = 2'h0;
   localparam [1:0] ST_WDATA = 2'h1;
   localparam [1:0] ST_RDATA = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Read flag and byte count for an address byte
   function [2:0] csp_len;
      input [7:0] a;
      begin
         case (a)
            `CSP_A_FLAGS, `CSP_A_DEC_DELTA, `CSP_A_ENC_DELTA:
               csp_len = {1'b1, `CSP_N_ONE};
            `CSP_A_DEC_LEVEL, `CSP_A_DEC_OFFSET, `CSP_A_DEC_LINEAR,
            `CSP_A_ENC_LEVEL, `CSP_A_ENC_OFFSET, `CSP_A_ENC_LINEAR:
               csp_len = {1'b1, `CSP_N_TWO};
            `CSP_A_TEST_IN:
               csp_len = {1'b0, `CSP_N_ONE};
            default:
               csp_len = {1'b0, `CSP_N_NONE};
         endcase
      end
   endfunction

   // Envelope magnitude to non-positive level, saturated
   function [15:0] csp_neg;
      input [15:0] mag;
      begin
         if (mag > `CSP_NEG_FULL)
            csp_neg = `CSP_NEG_FULL;
         else
            csp_neg = `CSP_ZERO16 - mag;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   reg hc_s1, hc_s2, hc_s3, sel_s1, sel_s2, cmd_s1, cmd_s2;
   reg dc_s1, dc_s2, dc_s3, st_s1, st_s2, st_prev, rx_s1, rx_s2;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {hc_s1, hc_s2, hc_s3} <= 3'h0;
         {sel_s1, sel_s2} <= 2'h3;
         {cmd_s1, cmd_s2} <= 2'h0;
         {dc_s1, dc_s2, dc_s3} <= 3'h0;
         {st_s1, st_s2} <= 2'h0;
         {rx_s1, rx_s2} <= 2'h0;
      end else begin
         {hc_s1, hc_s2, hc_s3} <= {hb_clk, hc_s1, hc_s2};
         {sel_s1, sel_s2} <= {hb_sel_n, sel_s1};
         {cmd_s1, cmd_s2} <= {hb_cmd, cmd_s1};
         {dc_s1, dc_s2, dc_s3} <= {dp_clk, dc_s1, dc_s2};
         {st_s1, st_s2} <= {frame_sync_strobe, st_s1};
         {rx_s1, rx_s2} <= {dp_rx, rx_s1};
      end
   end

   // Edges of the synchronised clocks
   wire hb_rise = hc_s2 & ~hc_s3 & ~sel_s2;
   wire hb_fall = ~hc_s2 & hc_s3 & ~sel_s2;
   wire dp_rise = dc_s2 & ~dc_s3;
   wire dp_fall = ~dc_s2 & dc_s3;

   ////////////////////////////////////////////////////////////////////////
   // Readout registers and voice flags
   reg [15:0] enc_level_reg, dec_level_reg, enc_off_reg, dec_off_reg;
   reg [15:0] enc_lin_reg, dec_lin_reg;
   reg        enc_vad_reg, dec_vad_reg;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enc_level_reg <= `CSP_ZERO16;
         dec_level_reg <= `CSP_ZERO16;
         enc_off_reg   <= `CSP_ZERO16;
         dec_off_reg   <= `CSP_ZERO16;
         enc_lin_reg   <= `CSP_ZERO16;
         dec_lin_reg   <= `CSP_ZERO16;
         enc_vad_reg   <= 1'b0;
         dec_vad_reg   <= 1'b0;
      end else begin
         enc_level_reg <= csp_neg(enc_envelope);
         dec_level_reg <= csp_neg(dec_envelope);
         enc_off_reg   <= ice_enable ? enc_offset_est
                                     : enc_offset_user;
         dec_off_reg   <= dec_offset_user;
         if (enc_linear_upd)
            enc_lin_reg <= enc_linear;
         if (dec_linear_upd)
            dec_lin_reg <= dec_linear;
         enc_vad_reg   <= enc_vad;
         dec_vad_reg   <= dec_vad;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Delta bit assembly, encoder side may take the test input
   reg [7:0] test_in_reg, enc_acc, dec_acc, enc_delta_reg, dec_delta_reg;
   reg [2:0] enc_idx, dec_idx;
   reg       enc_bit_reg;
   wire      enc_bit = delta_out_sel ? test_in_reg[`CSP_LAST_BIT - enc_idx]
                                     : enc_delta_bit;
   wire      enc_ref = enc_delta_upd & (enc_idx == `CSP_LAST_BIT);
   wire      dec_ref = dec_delta_upd & (dec_idx == `CSP_LAST_BIT);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enc_acc <= `CSP_ZERO8;
         dec_acc <= `CSP_ZERO8;
         enc_delta_reg <= `CSP_ZERO8;
         dec_delta_reg <= `CSP_ZERO8;
         enc_idx <= 3'h0;
         dec_idx <= 3'h0;
         enc_bit_reg <= 1'b0;
      end else begin
         if (enc_delta_upd) begin
            enc_acc <= {enc_acc[6:0], enc_bit};
            enc_idx <= enc_idx + 3'h1;
            enc_bit_reg <= enc_bit;
         end
         if (enc_ref)
            enc_delta_reg <= {enc_acc[6:0], enc_bit};
         if (dec_delta_upd) begin
            dec_acc <= {dec_acc[6:0], dec_delta_bit};
            dec_idx <= dec_idx + 3'h1;
         end
         if (dec_ref)
            dec_delta_reg <= {dec_acc[6:0], dec_delta_bit};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host bus byte engine
   reg  [1:0] hb_state;
   reg  [3:0] hb_bits;
   reg  [1:0] hb_left;
   reg  [7:0] hb_sh, hb_addr;
   reg  [7:0] evt_reg;
   wire [7:0] hb_in   = {hb_sh[6:0], cmd_s2};
   wire       hb_byte = hb_rise & (hb_bits == `CSP_BYTE_END);
   wire [2:0] hb_len  = csp_len(hb_in);
   wire       rd_go   = hb_byte & (hb_state == ST_ADDR) & hb_len[2];
   wire       wr_e8   = hb_byte & (hb_state == ST_WDATA) &
                        (hb_addr == `CSP_A_TEST_IN);
   wire [15:0] rq;
   reg  [15:0] rd_val;

   // Reply value, left aligned
   always @* begin
      case (hb_in)
         `CSP_A_FLAGS:      rd_val = {evt_reg, `CSP_ZERO8};
         `CSP_A_DEC_LEVEL:  rd_val = dec_level_reg;
         `CSP_A_DEC_OFFSET: rd_val = dec_off_reg;
         `CSP_A_DEC_LINEAR: rd_val = dec_lin_reg;
         `CSP_A_DEC_DELTA:  rd_val = {dec_delta_reg, `CSP_ZERO8};
         `CSP_A_ENC_LEVEL:  rd_val = enc_level_reg;
         `CSP_A_ENC_OFFSET: rd_val = enc_off_reg;
         `CSP_A_ENC_LINEAR: rd_val = enc_lin_reg;
         `CSP_A_ENC_DELTA:  rd_val = {enc_delta_reg, `CSP_ZERO8};
         default:           rd_val = `CSP_ZERO16;
      endcase
   end

   // Byte framing after each address byte
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hb_state <= ST_ADDR;
         hb_bits <= 4'h0;
         hb_left <= `CSP_N_NONE;
         hb_sh <= `CSP_ZERO8;
         hb_addr <= `CSP_ZERO8;
         test_in_reg <= `CSP_ZERO8;
      end else if (sel_s2) begin
         hb_state <= ST_ADDR;
         hb_bits <= 4'h0;
      end else if (hb_rise) begin
         hb_sh <= hb_in;
         hb_bits <= hb_byte ? 4'h0 : hb_bits + 4'h1;
         if (hb_byte) begin
            case (hb_state)
               ST_ADDR: begin
                  hb_addr <= hb_in;
                  hb_left <= hb_len[1:0];
                  if (hb_len[2])
                     hb_state <= ST_RDATA;
                  else if (hb_len[1:0] != `CSP_N_NONE)
                     hb_state <= ST_WDATA;
               end
               ST_WDATA: begin
                  if (wr_e8)
                     test_in_reg <= hb_in;
                  hb_left <= hb_left - 2'h1;
                  if (hb_left == `CSP_N_ONE)
                     hb_state <= ST_ADDR;
               end
               ST_RDATA: begin
                  hb_left <= hb_left - 2'h1;
                  if (hb_left == `CSP_N_ONE)
                     hb_state <= ST_ADDR;
               end
               default: hb_state <= ST_ADDR;
            endcase
         end
      end
   end

   // Reply shifter, bits change on the falling host clock
   csp_shreg u_reply (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .load     (rd_go),
      .load_val (rd_val),
      .shift    (hb_fall & (hb_state == ST_RDATA)),
      .ser_in   (1'b0),
      .q_reg    (rq)
   );

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hb_reply_reg <= 1'b0;
         hb_reply_oe_reg <= 1'b0;
      end else begin
         if (hb_fall & (hb_state == ST_RDATA))
            hb_reply_reg <= rq[15];
         hb_reply_oe_reg <= ~sel_s2 & (hb_state == ST_RDATA);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event flags and interrupt; a set beats a clear in the same cycle
   wire clr_stat = rd_go & (hb_in == `CSP_A_FLAGS);
   wire clr_epcm = rd_go & (hb_in == `CSP_A_ENC_LINEAR);
   wire clr_eadm = (rd_go & (hb_in == `CSP_A_ENC_DELTA)) | wr_e8;
   wire clr_dpcm = rd_go & (hb_in == `CSP_A_DEC_LINEAR);
   wire clr_dadm = rd_go & (hb_in == `CSP_A_DEC_DELTA);
   wire vad_chg  = (enc_vad ^ enc_vad_reg) | (dec_vad ^ dec_vad_reg);
   wire irq_set  = vad_chg |
                   (enc_linear_upd & ie_enc_linear) |
                   (enc_ref & ie_enc_delta) |
                   (dec_linear_upd & ie_dec_linear) |
                   (dec_ref & ie_dec_delta);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         evt_reg <= `CSP_ZERO8;
         irq_reg <= 1'b0;
      end else begin
         evt_reg[`CSP_S_ENC_ZERO] <= 1'b0;
         evt_reg[`CSP_S_DEC_ZERO] <= 1'b0;
         evt_reg[`CSP_S_ENC_VAD] <= enc_vad;
         evt_reg[`CSP_S_DEC_VAD] <= dec_vad;
         evt_reg[`CSP_S_ENC_PCM] <= enc_linear_upd |
            (evt_reg[`CSP_S_ENC_PCM] & ~clr_epcm);
         evt_reg[`CSP_S_ENC_ADM] <= enc_ref |
            (evt_reg[`CSP_S_ENC_ADM] & ~clr_eadm);
         evt_reg[`CSP_S_DEC_PCM] <= dec_linear_upd |
            (evt_reg[`CSP_S_DEC_PCM] & ~clr_dpcm);
         evt_reg[`CSP_S_DEC_ADM] <= dec_ref |
            (evt_reg[`CSP_S_DEC_ADM] & ~clr_dadm);
         irq_reg <= irq_set | (irq_reg & ~clr_stat);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sample port word selection
   reg  [4:0]  wlen;
   reg  [15:0] tx_word;
   reg  [4:0]  tx_left, rx_got;
   reg         rx_take;
   wire [15:0] tq, rxq;
   wire        new_sync = dp_rise & st_s2 & ~st_prev;
   wire        nb_load  = dp_rise & ~burst_mode & (tx_left <= `CSP_W_ONE);
   wire        tx_load  = burst_mode ? new_sync : nb_load;
   wire        tx_shift = dp_rise & (tx_left != 5'h00);
   wire [15:0] rx_next  = {rxq[14:0], rx_s2};

   // Width and content per coding algorithm
   always @* begin
      case (codec_mode)
         `CSP_M_LINEAR: begin
            wlen = `CSP_W_WORD;
            tx_word = enc_lin_reg;
         end
         `CSP_M_COMP: begin
            wlen = `CSP_W_BYTE;
            tx_word = `CSP_ZERO16;
            tx_word[8 + `CSP_C_SIGN] = enc_sign;
            tx_word[15:8] = {enc_sign, enc_exp, enc_mant};
         end
         default: begin
            wlen = burst_mode ? `CSP_W_BYTE : `CSP_W_ONE;
            tx_word = burst_mode ? {enc_delta_reg, `CSP_ZERO8}
                                 : {enc_bit_reg, 15'h0000};
         end
      endcase
   end

   // Transmit word held until shifted out
   csp_shreg u_tx (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .load     (tx_load),
      .load_val (tx_word),
      .shift    (tx_shift),
      .ser_in   (1'b0),
      .q_reg    (tq)
   );

   // Receive word gathered msb first
   csp_shreg u_rx (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .load     (1'b0),
      .load_val (`CSP_ZERO16),
      .shift    (dp_fall & rx_take),
      .ser_in   (rx_s2),
      .q_reg    (rxq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sample port bit timing
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_prev <= 1'b0;
         tx_left <= 5'h00;
         rx_take <= 1'b0;
         rx_got <= 5'h00;
         dp_tx_reg <= 1'b0;
         dp_tx_oe_reg <= 1'b0;
         rx_word_reg <= `CSP_ZERO16;
         rx_word_upd_reg <= 1'b0;
      end else begin
         rx_word_upd_reg <= 1'b0;
         if (dp_rise) begin
            st_prev <= st_s2;
            rx_take <= (tx_left != 5'h00) | ~burst_mode;
         end
         // Last bit of a word and the next strobe may share an edge
         if (tx_shift)
            dp_tx_reg <= tq[15];
         if (tx_load)
            tx_left <= wlen;
         else if (tx_shift)
            tx_left <= tx_left - 5'h01;
         if (tx_load | (tx_left != 5'h00) | tx_shift)
            dp_tx_oe_reg <= 1'b1;
         else
            dp_tx_oe_reg <= ~tx_float;
         if (new_sync & burst_mode)
            rx_got <= 5'h00;
         else if (dp_fall & rx_take) begin
            rx_take <= 1'b0;
            if (rx_got == wlen - 5'h01) begin
               rx_got <= 5'h00;
               rx_word_upd_reg <= 1'b1;
               rx_word_reg <= (wlen == `CSP_W_WORD) ? rx_next
                  : (wlen == `CSP_W_BYTE) ? {`CSP_ZERO8, rx_next[7:0]}
                  : {15'h0000, rx_s2};
            end else begin
               rx_got <= rx_got + 5'h01;
            end
         end
      end
   end

endmodule // csp_top

// ### tb/csp_top_properties.sv
// Checker for the codec status and sample port block.
// Sees only the top module ports; bound from the testbench top file.
`timescale 1ns/1ps

module csp_top_checker (
   // Clock and reset
   input wire        sys_clk,
   input wire        rst,
   // Host bus
   input wire        hb_clk,
   input wire        hb_sel_n,
   input wire        hb_reply_reg,
   input wire        hb_reply_oe_reg,
   input wire        irq_reg,
   // Sample port
   input wire        dp_clk,
   input wire        dp_tx_reg,
   input wire        dp_tx_oe_reg,
   input wire [15:0] rx_word_reg,
   input wire        rx_word_upd_reg,
   // Events
   input wire        enc_vad,
   input wire        dec_vad,
   input wire        enc_linear_upd,
   input wire        dec_linear_upd,
   input wire        enc_delta_upd,
   input wire        dec_delta_upd,
   input wire        ie_enc_linear,
   input wire        ie_dec_linear,
   input wire        ie_enc_delta,
   input wire        ie_dec_delta
);
   reg [2:0] enc_cnt_reg;
   reg [2:0] dec_cnt_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Delta bit counters, byte done on every eighth strobe
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enc_cnt_reg <= 3'h0;
         dec_cnt_reg <= 3'h0;
      end else begin
         enc_cnt_reg <= enc_cnt_reg + {2'h0, enc_delta_upd};
         dec_cnt_reg <= dec_cnt_reg + {2'h0, dec_delta_upd};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request shortly after its cause
   sequence s_irq;
      ##[1:4] irq_reg;
   endsequence

   AST_VAD_IRQ: assert property (
      $changed(enc_vad) || $changed(dec_vad) |-> s_irq)
      else $error("voice flag change gave no irq");
   AST_ENC_LIN_IRQ: assert property (
      ie_enc_linear && enc_linear_upd |-> s_irq)
      else $error("encoder linear update gave no irq");
   AST_DEC_LIN_IRQ: assert property (
      ie_dec_linear && dec_linear_upd |-> s_irq)
      else $error("decoder linear update gave no irq");
   AST_ENC_DELTA_IRQ: assert property (
      ie_enc_delta && enc_delta_upd && enc_cnt_reg == 3'h7 |-> s_irq)
      else $error("encoder delta byte gave no irq");
   AST_DEC_DELTA_IRQ: assert property (
      ie_dec_delta && dec_delta_upd && dec_cnt_reg == 3'h7 |-> s_irq)
      else $error("decoder delta byte gave no irq");
   AST_IRQ_HOLD: assert property (
      $fell(irq_reg) |-> !hb_sel_n)
      else $error("irq dropped outside a host transfer");
   AST_OE_START: assert property (
      $rose(hb_reply_oe_reg) |-> !hb_sel_n && hb_clk)
      else $error("reply enabled outside address byte end");
   AST_REPLY_FALL: assert property (
      hb_reply_oe_reg && $past(hb_reply_oe_reg) && $changed(hb_reply_reg)
      |-> !hb_clk)
      else $error("reply bit moved while host clock high");
   AST_TX_RISE: assert property (
      dp_tx_oe_reg && $changed(dp_tx_reg) |-> dp_clk)
      else $error("transmit bit moved off a rising clock");
   AST_RX_WORD: assert property (
      $changed(rx_word_reg) |-> rx_word_upd_reg || $past(rx_word_upd_reg))
      else $error("receive word moved without update pulse");
endmodule // csp_top_checker

// ### tb/csp_stream_ctl.sv
// Sample stream controller model for the burst data port.
// Assumes the block samples strobe on clock rise and rx on clock fall.
`timescale 1ns/1ps

module csp_stream_ctl (
   // Port signals
   output reg dp_clk,
   output reg frame_sync_strobe,
   output reg dp_rx,
   input wire dp_tx_reg
);
   ////////////////////////////////////////////////////////////////////////
   // Free running bit clock, 160 ns period
   initial begin
      dp_clk = 0;
      frame_sync_strobe = 0;
      dp_rx = 0;
   end
   always #80 dp_clk = ~dp_clk;

   ////////////////////////////////////////////////////////////////////////
   // One burst frame: strobe, then n bits each way, msb first
   task frame(input [15:0] w, input integer n, output [15:0] got);
      integer i;
      begin
         got = 16'h0000;
         @(negedge dp_clk) frame_sync_strobe <= 1;
         @(posedge dp_clk);
         @(negedge dp_clk) frame_sync_strobe <= 0;
         for (i = n - 1; i >= 0; i = i - 1) begin
            @(posedge dp_clk) dp_rx <= w[i];
            @(negedge dp_clk) got = {got[14:0], dp_tx_reg};
         end
         // Released line shows the inverse of the last bit
         @(posedge dp_clk) dp_rx <= ~dp_rx;
      end
   endtask
endmodule // csp_stream_ctl

// ### tb/csp_top_tb_top.sv
// Testbench top for the codec status, readout and sample port block.
// Assumes the host bus half period of 8 system clocks is legal.
`timescale 1ns/1ps

module csp_top_tb_top;
   reg sys_clk = 0, rst = 1, hb_clk = 0, hb_sel_n = 1, hb_cmd = 0;
   reg burst_mode = 1, tx_float = 1, delta_out_sel = 0, ice_enable = 0;
   reg ie_enc_linear = 0, ie_enc_delta = 0, ie_dec_linear = 0;
   reg ie_dec_delta = 0, enc_vad = 0, dec_vad = 0, enc_sign = 1;
   reg enc_linear_upd = 0, dec_linear_upd = 0, enc_delta_bit = 0;
   reg enc_delta_upd = 0, dec_delta_bit = 0, dec_delta_upd = 0;
   reg [1:0] codec_mode = 2'h2;
   reg [2:0] enc_exp = 3'h5;
   reg [3:0] enc_mant = 4'hA;
   reg [15:0] enc_envelope = 16'h0123, dec_envelope = 16'h9000;
   reg [15:0] enc_offset_user = 16'h7FFF, enc_offset_est = 16'h8001;
   reg [15:0] dec_offset_user = 16'h8000, enc_linear = 16'h8000;
   reg [15:0] dec_linear = 16'h7FFF, got;
   wire hb_reply_reg, hb_reply_oe_reg, irq_reg, dp_clk, dp_rx;
   wire frame_sync_strobe, dp_tx_reg, dp_tx_oe_reg, rx_word_upd_reg;
   wire [15:0] rx_word_reg;
   integer failures, tests_run;

   csp_top u_dut (.*);
   csp_stream_ctl u_ctl (.*);

   always #2.5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task tick(input integer n);
      begin
         repeat (n) @(negedge sys_clk);
      end
   endtask
   task chk(input [15:0] g, input [15:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task stop_test;
      begin
         if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // Host read: address byte then n reply bytes, msb first
   task rchk(input [7:0] a, input integer n, input [15:0] e);
      integer i;
      reg [15:0] d;
      begin
         d = 16'h0000;
         hb_sel_n = 0;
         for (i = 0; i < 8 + 8 * n; i = i + 1) begin
            hb_cmd = (i < 8) ? a[7 - i] : 1'b0;
            tick(8);
            if (i >= 8) d = {d[14:0], hb_reply_reg};
            hb_clk = 1;
            tick(8);
            hb_clk = 0;
         end
         tick(8);
         hb_sel_n = 1;
         tick(8);
         chk(d, e);
      end
   endtask
   // Host write: address byte then one data byte, msb first
   task wr(input [7:0] a, input [7:0] v);
      integer i;
      reg [15:0] s;
      begin
         s = {a, v};
         hb_sel_n = 0;
         for (i = 15; i >= 0; i = i - 1) begin
            hb_cmd = s[i];
            tick(8);
            hb_clk = 1;
            tick(8);
            hb_clk = 0;
         end
         tick(8);
         hb_sel_n = 1;
         tick(8);
      end
   endtask
   // Eight delta bit strobes, no irq before the eighth
   task delta(input dec, input [7:0] v);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            if (i == 0) chk(irq_reg, 0);
            enc_delta_bit = v[i];
            dec_delta_bit = v[i];
            enc_delta_upd = !dec;
            dec_delta_upd = dec;
            tick(1);
            enc_delta_upd = 0;
            dec_delta_upd = 0;
            tick(2);
         end
         tick(4);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (60000) @(posedge sys_clk);
      failures = failures + 1;
      stop_test;
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      failures = 0;
      tests_run = 0;
      tick(10);
      rst = 0;
      tick(4);
      rchk(8'h80, 1, 16'h0000);
      enc_vad = 1;
      tick(40);
      chk(irq_reg, 1);
      rchk(8'h80, 1, 16'h0040);
      chk(irq_reg, 0);
      enc_vad = 0;
      dec_vad = 1;
      tick(6);
      rchk(8'h80, 1, 16'h0004);
      rchk(8'hE4, 2, 16'hFEDD);
      rchk(8'hD4, 2, 16'h8000);
      rchk(8'hE5, 2, 16'h7FFF);
      rchk(8'hD5, 2, 16'h8000);
      ice_enable = 1;
      ie_enc_linear = 1;
      ie_dec_linear = 1;
      ie_enc_delta = 1;
      ie_dec_delta = 1;
      tick(2);
      rchk(8'hE5, 2, 16'h8001);
      enc_linear_upd = 1;
      tick(1);
      enc_linear_upd = 0;
      tick(6);
      chk(irq_reg, 1);
      rchk(8'h80, 1, 16'h0024);
      rchk(8'hE6, 2, 16'h8000);
      rchk(8'h80, 1, 16'h0004);
      dec_linear_upd = 1;
      tick(1);
      dec_linear_upd = 0;
      tick(6);
      chk(irq_reg, 1);
      rchk(8'h80, 1, 16'h0006);
      rchk(8'hD6, 2, 16'h7FFF);
      rchk(8'h80, 1, 16'h0004);
      delta(0, 8'hA5);
      chk(irq_reg, 1);
      rchk(8'h80, 1, 16'h0014);
      rchk(8'hEA, 1, 16'h00A5);
      rchk(8'h80, 1, 16'h0004);
      delta(1, 8'h3C);
      chk(irq_reg, 1);
      rchk(8'h80, 1, 16'h0005);
      rchk(8'hDA, 1, 16'h003C);
      rchk(8'h80, 1, 16'h0004);
      // Host written test bits replace encoder bits
      delta_out_sel = 1;
      wr(8'hE8, 8'h96);
      delta(0, 8'h00);
      rchk(8'h80, 1, 16'h0014);
      wr(8'hE8, 8'h55);
      rchk(8'h80, 1, 16'h0004);
      rchk(8'hEA, 1, 16'h0096);
      // Disabled linear irq stays quiet
      ie_dec_linear = 0;
      dec_linear_upd = 1;
      tick(1);
      dec_linear_upd = 0;
      tick(6);
      chk(irq_reg, 0);
      u_ctl.frame(16'h005A, 8, got);
      tick(6);
      chk(got, 16'h00DA);
      chk(rx_word_reg, 16'h005A);
      codec_mode = 2'h1;
      u_ctl.frame(16'hBEEF, 16, got);
      tick(6);
      chk(rx_word_reg, 16'hBEEF);
      chk(got, 16'h8000);
      tick(100);
      chk(dp_tx_oe_reg, 0);
      tx_float = 0;
      tick(2);
      chk(dp_tx_oe_reg, 1);
      // Delta burst frame carries the assembled byte
      codec_mode = 2'h0;
      u_ctl.frame(16'h00C3, 8, got);
      tick(6);
      chk(got, 16'h0096);
      chk(rx_word_reg, 16'h00C3);
      // Bit-serial mode, one bit per clock
      delta_out_sel = 0;
      delta(0, 8'h01);
      burst_mode = 0;
      u_ctl.frame(16'h0001, 1, got);
      tick(6);
      chk(got, 16'h0001);
      chk(rx_word_reg, 16'h0001);
      stop_test;
   end
endmodule // csp_top_tb_top

bind csp_top csp_top_checker u_chk (.*);
